// ==== include/sgc_pkg.sv ====
package sgc_pkg;

  //////////////////////////////////////////////////////////////////////////////
  // Register offsets on the management port
  localparam logic [7:0] GC0_ADDR = 8'h02;
  localparam logic [7:0] GC1_ADDR = 8'h03;

  // Global control zero field positions
  localparam int GC0_FLUSH_BIT = 4;
  localparam int GC0_CONF_BIT = 1;
  localparam int GC0_LINK_AGE_BIT = 0;
  // Bits 3 and 2 are fixed, read as one
  localparam logic [7:0] GC0_FIXED_ONES = 8'h0c;

  // Global control one field positions
  localparam int GC1_PASS_ALL_BIT = 7;
  localparam int GC1_2K_BIT = 6;
  localparam int GC1_TX_PAUSE_DIS_BIT = 5;
  localparam int GC1_RX_PAUSE_DIS_BIT = 4;
  localparam int GC1_LEN_CHECK_BIT = 3;
  localparam int GC1_AGING_BIT = 2;
  localparam int GC1_FAST_AGE_BIT = 1;
  localparam int GC1_BACKOFF_BIT = 0;

  // Reset values; strap-driven bits overlaid at reset
  localparam logic [7:0] GC0_RESET = 8'h00;
  localparam logic [7:0] GC1_RESET = 8'h04;

  //////////////////////////////////////////////////////////////////////////////
  // Frame classification constants
  localparam logic [15:0] FLOWCTL_TYPE = 16'h8808;
  localparam logic [47:0] FLOWCTL_DA = 48'h0180c2000001;
  localparam logic [15:0] LEN_FIELD_LIMIT = 16'h05dc;
  localparam logic [15:0] MAX_LEN_2K = 16'h0800;
  localparam logic [15:0] MAX_LEN_STD = 16'h0600;

  //////////////////////////////////////////////////////////////////////////////
  // Timing: clock rate and aging periods
  localparam longint CLK_HZ = 40_000_000;
  localparam longint AGE_NORMAL_S = 300;
  localparam longint AGE_TOL_S = 75;
  localparam longint FAST_AGE_US = 800;
  localparam logic [33:0] AGE_NORMAL_CYC = 34'(AGE_NORMAL_S * CLK_HZ);
  // Longest time, rounded down
  localparam logic [33:0] FAST_AGE_CYC = 34'((FAST_AGE_US * CLK_HZ) / 1_000_000);

  // Flush engine states
  typedef enum logic [0:0] {
    FL_IDLE = 1'b0,
    FL_SCAN = 1'b1
  } sgc_flush_state_e;

endpackage

// ==== include/sgc_flush_if.sv ====
interface sgc_flush_if #(
  parameter int IW = 5,
  parameter int PORTS = 4
);
  logic start;
  logic busy;
  logic done;
  logic [IW-1:0] scan_idx;
  logic [IW-1:0] clr_idx;
  logic clear;
  logic entry_valid;
  logic [PORTS-1:0] entry_ports;
  logic entry_mcast;
  logic [PORTS-1:0] learn_dis;

  modport ctrl (
    output start, entry_valid, entry_ports, entry_mcast, learn_dis,
    input busy, done, scan_idx, clr_idx, clear
  );
  modport engine (
    input start, entry_valid, entry_ports, entry_mcast, learn_dis,
    output busy, done, scan_idx, clr_idx, clear
  );
endinterface

// ==== design/sgc_flush_engine.sv ====
module sgc_flush_engine #(
  parameter int ENTRIES = 32,
  parameter int PORTS = 4
) (
  input wire logic i_clk,
  input wire logic i_reset,
  sgc_flush_if.engine fl
);
  localparam int IW = $clog2(ENTRIES);
  localparam logic [IW-1:0] LAST_IDX = IW'(ENTRIES - 1);

  // Exactly one port named in the set
  function automatic logic single_port(input logic [PORTS-1:0] p);
    return (p != '0) && ((p & (p - 1'b1)) == '0);
  endfunction

  sgc_pkg::sgc_flush_state_e state;
  sgc_pkg::sgc_flush_state_e next_state;
  wire logic scanning = (state == sgc_pkg::FL_SCAN);
  wire logic at_last = (fl.scan_idx == LAST_IDX);
  wire logic match = fl.entry_valid && single_port(fl.entry_ports) && !fl.entry_mcast
                     && ((fl.entry_ports & fl.learn_dis) != '0);

  // Scan walks every entry once, one per cycle
  always_comb
  begin
    case (state)
      sgc_pkg::FL_IDLE: next_state = fl.start ? sgc_pkg::FL_SCAN : sgc_pkg::FL_IDLE;
      sgc_pkg::FL_SCAN: next_state = at_last ? sgc_pkg::FL_IDLE : sgc_pkg::FL_SCAN;
      default: next_state = sgc_pkg::FL_IDLE;
    endcase
  end

  always_ff @(posedge i_clk)
  begin
    if (i_reset)
    begin
      state <= sgc_pkg::FL_IDLE;
      fl.scan_idx <= '0;
      fl.clr_idx <= '0;
      fl.clear <= 1'b0;
      fl.done <= 1'b0;
    end
    else
    begin
      state <= next_state;
      fl.scan_idx <= scanning ? fl.scan_idx + 1'b1 : '0;
      fl.clr_idx <= fl.scan_idx;
      fl.clear <= scanning && match;
      fl.done <= scanning && at_last;
    end
  end

  assign fl.busy = scanning;

  // Multicast or multi-port entries stay put
  unmatched_kept_a: assert property (@(posedge i_clk) disable iff (i_reset)
    scanning && (fl.entry_mcast || !single_port(fl.entry_ports)) |=> !fl.clear)
    else $error("non-matching static entry was cleared");

endmodule // sgc_flush_engine

// ==== design/sgc_switch_ctrl.sv ====
module sgc_switch_ctrl #(
  parameter int PORTS = 4,
  parameter int ENTRIES = 32,
  parameter logic [33:0] NORMAL_AGE_CYC = sgc_pkg::AGE_NORMAL_CYC,
  parameter logic [33:0] FAST_AGE_CYC = sgc_pkg::FAST_AGE_CYC,
  parameter logic [15:0] MAX_STD_LEN = sgc_pkg::MAX_LEN_STD
) (
  input wire logic i_clk,
  input wire logic i_reset,
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  input wire logic [7:0] i_reg_addr,
  input wire logic [7:0] i_reg_wdata,
  output logic [7:0] o_reg_rdata,
  input wire logic i_pause_default_strap_pin,
  input wire logic i_backoff_default_strap_pin,
  input wire logic [PORTS-1:0] i_link_up,
  input wire logic [PORTS-1:0] i_learn_dis,
  output logic [$clog2(ENTRIES)-1:0] o_stat_rd_idx,
  output logic [$clog2(ENTRIES)-1:0] o_stat_clr_idx,
  output logic o_stat_clear,
  input wire logic i_stat_valid,
  input wire logic [PORTS-1:0] i_stat_ports,
  input wire logic i_stat_mcast,
  input wire logic [PORTS-1:0] i_an_tx_pause,
  input wire logic [PORTS-1:0] i_an_rx_pause,
  output logic [PORTS-1:0] o_tx_fc_en,
  output logic [PORTS-1:0] o_rx_fc_en,
  input wire logic i_frm_valid,
  input wire logic [15:0] i_frm_type,
  input wire logic [47:0] i_frm_da,
  input wire logic i_frm_is_pause,
  input wire logic i_frm_bad,
  input wire logic [15:0] i_frm_payload_len,
  input wire logic [15:0] i_frm_size,
  output logic o_frm_done,
  output logic o_frm_drop,
  output logic o_age_tick,
  output logic o_age_all,
  output logic o_fast_pending,
  output logic o_aggr_backoff,
  output logic o_flush_busy
);

  localparam int IW = $clog2(ENTRIES);

  //////////////////////////////////////////////////////////////////////////////
  // Flush engine hookup
  sgc_flush_if #(.IW(IW), .PORTS(PORTS)) fl ();

  sgc_flush_engine #(.ENTRIES(ENTRIES), .PORTS(PORTS)) u_flush (
    .i_clk(i_clk),
    .i_reset(i_reset),
    .fl(fl.engine)
  );

  logic flush_start;
  assign fl.start = flush_start;
  assign fl.entry_valid = i_stat_valid;
  assign fl.entry_ports = i_stat_ports;
  assign fl.entry_mcast = i_stat_mcast;
  assign fl.learn_dis = i_learn_dis;
  // Engine drives these from its own flops
  assign o_stat_rd_idx = fl.scan_idx;
  assign o_stat_clr_idx = fl.clr_idx;
  assign o_stat_clear = fl.clear;

  //////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers; first stage read only by second
  logic pause_strap_s1;
  logic pause_strap_s2;
  logic backoff_strap_s1;
  logic backoff_strap_s2;
  logic [PORTS-1:0] link_s1;
  logic [PORTS-1:0] link_s2;
  logic [PORTS-1:0] link_s3;

  always_ff @(posedge i_clk)
  begin
    pause_strap_s1 <= i_pause_default_strap_pin;
    pause_strap_s2 <= pause_strap_s1;
    backoff_strap_s1 <= i_backoff_default_strap_pin;
    backoff_strap_s2 <= backoff_strap_s1;
    link_s1 <= i_link_up;
    link_s2 <= link_s1;
  end

  // Edge history tracks the pin through reset too; a constant here would
  // make links already down at release look like a fresh unplug
  always_ff @(posedge i_clk)
  begin
    link_s3 <= link_s2;
  end

  wire logic link_drop = |(link_s3 & ~link_s2);

  //////////////////////////////////////////////////////////////////////////////
  // Register fields
  logic conf_drop_mode;
  logic link_age_en;
  logic pass_all;
  logic accept_2k;
  logic tx_pause_dis;
  logic rx_pause_dis;
  logic len_check;
  logic aging_en;
  logic fast_age;

  wire logic wr_gc0 = i_reg_wr && (i_reg_addr == sgc_pkg::GC0_ADDR);
  wire logic wr_gc1 = i_reg_wr && (i_reg_addr == sgc_pkg::GC1_ADDR);
  // Flush is busy from the start pulse through the done pulse
  wire logic flush_active = flush_start || fl.busy || fl.done;
  wire logic flush_req = wr_gc0 && i_reg_wdata[sgc_pkg::GC0_FLUSH_BIT] && !flush_active;

  wire logic [7:0] gc0_view = sgc_pkg::GC0_FIXED_ONES
                              | (8'(flush_active) << sgc_pkg::GC0_FLUSH_BIT)
                              | (8'(conf_drop_mode) << sgc_pkg::GC0_CONF_BIT)
                              | (8'(link_age_en) << sgc_pkg::GC0_LINK_AGE_BIT);
  wire logic [7:0] gc1_view = {pass_all, accept_2k, tx_pause_dis, rx_pause_dis,
                               len_check, aging_en, fast_age, o_aggr_backoff};
  wire logic [7:0] rd_mux = (i_reg_addr == sgc_pkg::GC0_ADDR) ? gc0_view :
                            (i_reg_addr == sgc_pkg::GC1_ADDR) ? gc1_view : 8'h00;

  // Global control zero; writes during a flush leave it running
  always_ff @(posedge i_clk)
  begin
    if (i_reset)
    begin
      conf_drop_mode <= sgc_pkg::GC0_RESET[sgc_pkg::GC0_CONF_BIT];
      link_age_en <= sgc_pkg::GC0_RESET[sgc_pkg::GC0_LINK_AGE_BIT];
      flush_start <= 1'b0;
    end
    else
    begin
      flush_start <= flush_req;
      if (wr_gc0)
      begin
        conf_drop_mode <= i_reg_wdata[sgc_pkg::GC0_CONF_BIT];
        link_age_en <= i_reg_wdata[sgc_pkg::GC0_LINK_AGE_BIT];
      end
    end
  end

  // Global control one; strap levels caught while reset is held
  always_ff @(posedge i_clk)
  begin
    if (i_reset)
    begin
      pass_all <= sgc_pkg::GC1_RESET[sgc_pkg::GC1_PASS_ALL_BIT];
      accept_2k <= sgc_pkg::GC1_RESET[sgc_pkg::GC1_2K_BIT];
      tx_pause_dis <= pause_strap_s2;
      rx_pause_dis <= pause_strap_s2;
      len_check <= sgc_pkg::GC1_RESET[sgc_pkg::GC1_LEN_CHECK_BIT];
      aging_en <= sgc_pkg::GC1_RESET[sgc_pkg::GC1_AGING_BIT];
      fast_age <= sgc_pkg::GC1_RESET[sgc_pkg::GC1_FAST_AGE_BIT];
      o_aggr_backoff <= backoff_strap_s2;
    end
    else if (wr_gc1)
    begin
      pass_all <= i_reg_wdata[sgc_pkg::GC1_PASS_ALL_BIT];
      accept_2k <= i_reg_wdata[sgc_pkg::GC1_2K_BIT];
      tx_pause_dis <= i_reg_wdata[sgc_pkg::GC1_TX_PAUSE_DIS_BIT];
      rx_pause_dis <= i_reg_wdata[sgc_pkg::GC1_RX_PAUSE_DIS_BIT];
      len_check <= i_reg_wdata[sgc_pkg::GC1_LEN_CHECK_BIT];
      aging_en <= i_reg_wdata[sgc_pkg::GC1_AGING_BIT];
      fast_age <= i_reg_wdata[sgc_pkg::GC1_FAST_AGE_BIT];
      o_aggr_backoff <= i_reg_wdata[sgc_pkg::GC1_BACKOFF_BIT];
    end
  end

  // Read data holds between reads
  always_ff @(posedge i_clk)
  begin
    if (i_reset)
      o_reg_rdata <= 8'h00;
    else if (i_reg_rd)
      o_reg_rdata <= rd_mux;
  end

  always_ff @(posedge i_clk)
  begin
    if (i_reset)
      o_flush_busy <= 1'b0;
    else
      o_flush_busy <= flush_active;
  end

  //////////////////////////////////////////////////////////////////////////////
  // Pause enables per port
  always_ff @(posedge i_clk)
  begin
    if (i_reset)
    begin
      o_tx_fc_en <= '0;
      o_rx_fc_en <= '0;
    end
    else
    begin
      o_tx_fc_en <= tx_pause_dis ? '0 : i_an_tx_pause;
      o_rx_fc_en <= rx_pause_dis ? '0 : i_an_rx_pause;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Frame admission; verdict one cycle after the request
  wire logic is_fc_type = (i_frm_type == sgc_pkg::FLOWCTL_TYPE);
  wire logic is_fc_da = (i_frm_da == sgc_pkg::FLOWCTL_DA);
  wire logic drop_conf = conf_drop_mode && (is_fc_type || is_fc_da);
  wire logic drop_fc = !conf_drop_mode && i_frm_is_pause;
  wire logic drop_len = len_check && (i_frm_type < sgc_pkg::LEN_FIELD_LIMIT)
                        && (i_frm_type != i_frm_payload_len);
  wire logic [15:0] max_len = accept_2k ? sgc_pkg::MAX_LEN_2K : MAX_STD_LEN;
  wire logic drop_size = (i_frm_size > max_len);
  // errored frames pass only in pass-all
  wire logic drop_bad = i_frm_bad && !pass_all;
  wire logic next_drop = drop_conf || drop_fc || drop_len || drop_size || drop_bad;

  always_ff @(posedge i_clk)
  begin
    if (i_reset)
    begin
      o_frm_done <= 1'b0;
      o_frm_drop <= 1'b0;
    end
    else
    begin
      o_frm_done <= i_frm_valid;
      o_frm_drop <= i_frm_valid && next_drop;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Aging timer; fast period while fast bit or a link-loss pass is pending
  logic [33:0] age_cnt;
  wire logic fast_mode = fast_age || o_fast_pending;
  wire logic [33:0] age_limit = fast_mode ? FAST_AGE_CYC : NORMAL_AGE_CYC;
  wire logic age_expire = aging_en && (age_cnt >= age_limit - 34'd1);
  wire logic fast_set = link_age_en && link_drop;

  always_ff @(posedge i_clk)
  begin
    if (i_reset || !aging_en || fast_set || age_expire)
      age_cnt <= '0;
    else
      age_cnt <= age_cnt + 34'd1;
  end

  // Set beats clear: a new link loss rearms the pass
  always_ff @(posedge i_clk)
  begin
    if (i_reset)
      o_fast_pending <= 1'b0;
    else if (fast_set)
      o_fast_pending <= 1'b1;
    else if (age_expire)
      o_fast_pending <= 1'b0;
  end

  always_ff @(posedge i_clk)
  begin
    if (i_reset)
    begin
      o_age_tick <= 1'b0;
      o_age_all <= 1'b0;
    end
    else
    begin
      o_age_tick <= age_expire;
      o_age_all <= link_drop;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (i_reset);

  sequence s_flush_req;
    wr_gc0 && i_reg_wdata[sgc_pkg::GC0_FLUSH_BIT] && !o_flush_busy && !flush_active;
  endsequence
  sequence s_flush_run;
    flush_start ##1 fl.busy [*8];
  endsequence

  flush_start_run_a: assert property (s_flush_req |=> s_flush_run)
    else $error("flush request did not start a scan");
  flush_bit_hold_a: assert property ($fell(fl.busy) |-> fl.done ##1 !flush_active)
    else $error("flush bit did not clear after scan");
  conf_drop_a: assert property (i_frm_valid && conf_drop_mode && is_fc_type
    |=> o_frm_done && o_frm_drop)
    else $error("conformance frame not dropped");
  pause_drop_a: assert property (i_frm_valid && !conf_drop_mode && i_frm_is_pause
    |=> o_frm_drop)
    else $error("flow-control frame not dropped");
  bad_frame_a: assert property (i_frm_valid && i_frm_bad && !pass_all |=> o_frm_drop)
    else $error("errored frame forwarded without pass-all");
  tx_pause_off_a: assert property (tx_pause_dis |=> o_tx_fc_en == '0)
    else $error("transmit pause enabled while disabled");
  rx_pause_off_a: assert property (rx_pause_dis |=> o_rx_fc_en == '0)
    else $error("receive pause enabled while disabled");
  aging_off_a: assert property (!aging_en |=> !o_age_tick)
    else $error("aging tick while aging disabled");
  link_fast_a: assert property (fast_set |=> o_fast_pending && o_age_all)
    else $error("link loss did not arm fast aging");
  unplug_age_a: assert property (|($past(link_s2) & ~link_s2) |=> o_age_all)
    else $error("unplug did not age out addresses");

endmodule // sgc_switch_ctrl

// ==== verification/test_switch_global_control_regs.sv ====
module test_switch_global_control_regs;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int ENT = 32;
  localparam int FAST = 10;
  localparam int NORM = 40;
  localparam logic [47:0] DA0 = 48'h001122334455;
  localparam logic [7:0] GC0 = sgc_pkg::GC0_ADDR;
  localparam logic [7:0] GC1 = sgc_pkg::GC1_ADDR;
  logic i_clk = 1'b0;
  logic i_reset = 1'b1;
  logic i_reg_wr = 1'b0;
  logic i_reg_rd = 1'b0;
  logic [7:0] i_reg_addr = 8'h00;
  logic [7:0] i_reg_wdata = 8'h00;
  logic [3:0] i_link_up = 4'hf;
  logic i_pause_default_strap_pin = 1'b1;
  logic i_backoff_default_strap_pin = 1'b1;
  logic [3:0] i_learn_dis = 4'h2;
  logic [3:0] i_an_tx_pause = 4'h0;
  logic [3:0] i_an_rx_pause = 4'h0;
  logic i_frm_valid = 1'b0;
  logic i_frm_is_pause = 1'b0;
  logic i_frm_bad = 1'b0;
  logic [15:0] i_frm_type = 16'h0000;
  logic [47:0] i_frm_da = 48'h000000000000;
  logic [15:0] i_frm_payload_len = 16'h0000;
  logic [15:0] i_frm_size = 16'h0000;
  logic [7:0] o_reg_rdata;
  logic [4:0] o_stat_rd_idx, o_stat_clr_idx;
  logic [3:0] o_tx_fc_en, o_rx_fc_en, i_stat_ports;
  logic o_stat_clear, i_stat_valid, i_stat_mcast, o_frm_done, o_frm_drop;
  logic o_age_tick, o_age_all, o_fast_pending, o_aggr_backoff, o_flush_busy;
  int mismatches = 0;
  int total_checks = 0;
  int ticks = 0;
  logic [4:0] clr_log [$];

  //////////////////////////////////////////////////////////////////////////////
  // Clock, 25 ns period
  always #12.5 i_clk = ~i_clk;

  // Static table: 3 and 9 qualify; 5 multicast, 6 two ports, 12 learning port
  assign i_stat_valid = o_stat_rd_idx inside {5'h03, 5'h05, 5'h06, 5'h09, 5'h0c};
  assign i_stat_ports = (o_stat_rd_idx == 5'h06) ? 4'h3 : (o_stat_rd_idx == 5'h0c) ? 4'h4 : 4'h2;
  assign i_stat_mcast = (o_stat_rd_idx == 5'h05);

  // Log removals and aging passes as they happen; both are one-cycle pulses
  always @(posedge i_clk)
  begin
    if (o_stat_clear === 1'b1)
      clr_log.push_back(o_stat_clr_idx);
    if (o_age_tick === 1'b1)
      ticks++;
  end

  sgc_switch_ctrl #(.PORTS(4), .ENTRIES(ENT), .NORMAL_AGE_CYC(34'(NORM)),
    .FAST_AGE_CYC(34'(FAST))) i_dut (
    .i_clk(i_clk), .i_reset(i_reset), .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd),
    .i_reg_addr(i_reg_addr), .i_reg_wdata(i_reg_wdata), .o_reg_rdata(o_reg_rdata),
    .i_pause_default_strap_pin(i_pause_default_strap_pin),
    .i_backoff_default_strap_pin(i_backoff_default_strap_pin),
    .i_link_up(i_link_up), .i_learn_dis(i_learn_dis), .o_stat_rd_idx(o_stat_rd_idx),
    .o_stat_clr_idx(o_stat_clr_idx), .o_stat_clear(o_stat_clear),
    .i_stat_valid(i_stat_valid), .i_stat_ports(i_stat_ports), .i_stat_mcast(i_stat_mcast),
    .i_an_tx_pause(i_an_tx_pause), .i_an_rx_pause(i_an_rx_pause),
    .o_tx_fc_en(o_tx_fc_en), .o_rx_fc_en(o_rx_fc_en), .i_frm_valid(i_frm_valid),
    .i_frm_type(i_frm_type), .i_frm_da(i_frm_da), .i_frm_is_pause(i_frm_is_pause),
    .i_frm_bad(i_frm_bad), .i_frm_payload_len(i_frm_payload_len), .i_frm_size(i_frm_size),
    .o_frm_done(o_frm_done), .o_frm_drop(o_frm_drop), .o_age_tick(o_age_tick),
    .o_age_all(o_age_all), .o_fast_pending(o_fast_pending),
    .o_aggr_backoff(o_aggr_backoff), .o_flush_busy(o_flush_busy));

  //////////////////////////////////////////////////////////////////////////////
  // Shared helpers
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    total_checks++;
    if (got !== exp)
    begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_clk);
    i_reg_wr <= 1'b1;
    i_reg_addr <= a;
    i_reg_wdata <= d;
    @(posedge i_clk);
    i_reg_wr <= 1'b0;
  endtask

  // Read data is registered, so it is sampled one full cycle after the strobe
  task automatic rd_chk(input string what, input logic [7:0] a, input logic [7:0] exp);
    @(posedge i_clk);
    i_reg_rd <= 1'b1;
    i_reg_addr <= a;
    @(posedge i_clk);
    i_reg_rd <= 1'b0;
    @(posedge i_clk);
    #1 chk(what, exp, o_reg_rdata);
  endtask

  // Wait a bounded number of cycles for a level; returns cycles waited
  task automatic wait_for(ref logic sig, input int lim, output int n);
    n = 0;
    while (sig !== 1'b1 && n < lim)
    begin
      @(posedge i_clk);
      #1 n++;
    end
  endtask

  task automatic frm(input logic [15:0] t, input logic [47:0] da, input logic p, input logic b,
    input logic [15:0] pl, input logic [15:0] sz, input logic exp);
    int n;
    @(posedge i_clk);
    i_frm_valid <= 1'b1;
    i_frm_type <= t;
    i_frm_da <= da;
    i_frm_is_pause <= p;
    i_frm_bad <= b;
    i_frm_payload_len <= pl;
    i_frm_size <= sz;
    @(posedge i_clk);
    i_frm_valid <= 1'b0;
    #1 wait_for(o_frm_done, 2, n);
    chk("frame done", 8'h01, 8'(o_frm_done));
    chk("frame drop", 8'(exp), 8'(o_frm_drop));
  endtask

  //////////////////////////////////////////////////////////////////////////////
  // Scenarios
  task automatic t_reset;
    rd_chk("gc0 reset", GC0, sgc_pkg::GC0_RESET | sgc_pkg::GC0_FIXED_ONES);
    rd_chk("gc1 reset, straps high", GC1, sgc_pkg::GC1_RESET | 8'h31);
    rd_chk("unmapped read", 8'h07, 8'h00);
    chk("backoff after reset", 8'h01, 8'(o_aggr_backoff));
    $display("test reset done");
  endtask

  // Each pause bit programmed alone, with back-off toggled in the same table
  task automatic t_pause;
    logic [7:0] v [3];
    v = '{8'h14, 8'h25, 8'h04};
    @(posedge i_clk);
    i_an_tx_pause <= 4'ha;
    i_an_rx_pause <= 4'h6;
    for (int i = 0; i < 3; i++)
    begin
      wr(GC1, v[i]);
      repeat (2) @(posedge i_clk);
      #1 chk("tx flow ctl", v[i][5] ? 8'h00 : 8'h0a, 8'(o_tx_fc_en));
      chk("rx flow ctl", v[i][4] ? 8'h00 : 8'h06, 8'(o_rx_fc_en));
      chk("aggr backoff", 8'(v[i][0]), 8'(o_aggr_backoff));
    end
    $display("test pause done");
  endtask

  task automatic t_frames;
    wr(GC0, 8'h02);
    frm(16'h8808, DA0, 1'b0, 1'b0, 16'h0040, 16'h0100, 1'b1);
    frm(16'h0800, sgc_pkg::FLOWCTL_DA, 1'b0, 1'b0, 16'h0040, 16'h0100, 1'b1);
    frm(16'h0800, DA0, 1'b0, 1'b0, 16'h0040, 16'h0100, 1'b0);
    wr(GC0, 8'h00);
    frm(16'h8808, DA0, 1'b0, 1'b0, 16'h0040, 16'h0100, 1'b0);
    frm(16'h0800, DA0, 1'b1, 1'b0, 16'h0040, 16'h0100, 1'b1);
    frm(16'h0800, DA0, 1'b0, 1'b1, 16'h0040, 16'h0100, 1'b1);
    frm(16'h0800, DA0, 1'b0, 1'b0, 16'h0040, 16'h07d0, 1'b1);
    wr(GC1, 8'hc4);
    frm(16'h0800, DA0, 1'b0, 1'b1, 16'h0040, 16'h0100, 1'b0);
    frm(16'h0800, DA0, 1'b0, 1'b0, 16'h0040, 16'h07d0, 1'b0);
    wr(GC1, 8'h0c);
    frm(16'h0040, DA0, 1'b0, 1'b0, 16'h0030, 16'h0100, 1'b1);
    frm(16'h0040, DA0, 1'b0, 1'b0, 16'h0040, 16'h0100, 1'b0);
    frm(16'h05dc, DA0, 1'b0, 1'b0, 16'h0030, 16'h0100, 1'b0);
    wr(GC1, 8'h04);
    frm(16'h0040, DA0, 1'b0, 1'b0, 16'h0030, 16'h0100, 1'b0);
    $display("test frames done");
  endtask

  task automatic t_flush;
    int n;
    wr(GC0, 8'h10);
    rd_chk("flush bit while busy", GC0, 8'h1c);
    chk("flush busy", 8'h01, 8'(o_flush_busy));
    while (o_flush_busy !== 1'b0 && n < ENT + 10)
    begin
      @(posedge i_clk);
      #1 n++;
    end
    chk("flush ended", 8'h00, 8'(o_flush_busy));
    chk("scan index idle", 8'h00, 8'(o_stat_rd_idx));
    repeat (2) @(posedge i_clk);
    rd_chk("flush bit after done", GC0, 8'h0c);
    chk("removed count", 8'h02, 8'(clr_log.size()));
    if (clr_log.size() == 2)
    begin
      chk("first removed", 8'h03, 8'(clr_log[0]));
      chk("second removed", 8'h09, 8'(clr_log[1]));
    end
    $display("test flush done");
  endtask

  task automatic t_aging;
    int n;
    wr(GC0, 8'h01);
    @(posedge i_clk);
    i_link_up <= 4'hb;
    #1 wait_for(o_age_all, 8, n);
    chk("age all on drop", 8'h01, 8'(o_age_all));
    chk("fast pass pending", 8'h01, 8'(o_fast_pending));
    // Start one cycle on: a normal tick may share the drop cycle
    @(posedge i_clk);
    #1 wait_for(o_age_tick, FAST + 8, n);
    chk("fast period", 8'h01, 8'(n >= FAST - 2 && n <= FAST + 2));
    repeat (2) @(posedge i_clk);
    #1 chk("pending cleared", 8'h00, 8'(o_fast_pending));
    wait_for(o_age_tick, NORM + 8, n);
    chk("back to normal period", 8'h01, 8'(n >= NORM - 4 && o_age_tick === 1'b1));
    wr(GC0, 8'h00);
    @(posedge i_clk);
    i_link_up <= 4'h3;
    #1 wait_for(o_age_all, 8, n);
    chk("age all, no fast", 8'h01, 8'(o_age_all));
    chk("no fast pending", 8'h00, 8'(o_fast_pending));
    wr(GC1, 8'h00);
    // A tick launched just before the write is still in flight
    repeat (2) @(posedge i_clk);
    ticks = 0;
    repeat (NORM * 3) @(posedge i_clk);
    chk("ticks while off", 8'h00, 8'(ticks));
    wr(GC1, 8'h04);
    repeat (NORM * 2 + 4) @(posedge i_clk);
    chk("ticks when on", 8'h01, 8'(ticks > 0));
    $display("test aging done");
  endtask

  // Second reset with straps low and links down: pull-down defaults, no false unplug
  task automatic t_strap;
    wr(GC1, 8'h35);
    @(posedge i_clk);
    i_reset <= 1'b1;
    i_pause_default_strap_pin <= 1'b0;
    i_backoff_default_strap_pin <= 1'b0;
    repeat (4) @(posedge i_clk);
    i_reset <= 1'b0;
    @(posedge i_clk);
    #1 chk("age all after reset", 8'h00, 8'(o_age_all));
    chk("backoff strap low", 8'h00, 8'(o_aggr_backoff));
    chk("tx flow ctl strap low", 8'h0a, 8'(o_tx_fc_en));
    chk("rx flow ctl strap low", 8'h06, 8'(o_rx_fc_en));
    rd_chk("gc1 reset, straps low", GC1, sgc_pkg::GC1_RESET);
    rd_chk("gc0 after second reset", GC0, 8'h0c);
    $display("test strap done");
  endtask

  //////////////////////////////////////////////////////////////////////////////
  // Verdict and run control
  task automatic final_report;
    $display("checks %0d, mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // Whole run is a few hundred cycles; this bound is far beyond it
  initial
  begin
    #(25 * 20000);
    mismatches++;
    $display("watchdog expired");
    final_report;
  end

  initial
  begin
    repeat (3) @(posedge i_clk);
    i_reset <= 1'b0;
    t_reset;
    t_pause;
    t_frames;
    t_flush;
    t_aging;
    t_strap;
    final_report;
  end
endmodule // test_switch_global_control_regs
